// ===== ocs_defs.vh
`ifndef OCS_DEFS_VH
`define OCS_DEFS_VH
// Clock rate and derived tick counts.
`define OCS_CLK_HZ 40000000
`define OCS_TICK_MS 1
`define OCS_TICK_CYCLES ((`OCS_CLK_HZ / 1000) * `OCS_TICK_MS)
`define OCS_SAMPLE_MS 5
`define OCS_AVG_MS 20
`define OCS_AVG_SAMPLES (`OCS_AVG_MS / `OCS_SAMPLE_MS)
// Release delay defaults, in 5 ms steps (60 ms).
`define OCS_REL_DELAY_MS 60
`define OCS_REL_STEPS_RST (`OCS_REL_DELAY_MS / `OCS_SAMPLE_MS)
// Threshold in units of 0.01 x nominal; default 1.20.
`define OCS_THR_RST 16'h0078
// Hysteresis as 97/100.
`define OCS_HYS_NUM 97
`define OCS_HYS_DEN 100
// Magnitude selector codes.
`define OCS_MAG_RMS 2'h1
`define OCS_MAG_TRMS 2'h2
`define OCS_MAG_PP 2'h3
// Operating modes.
`define OCS_OP_INSTANT 2'h0
`define OCS_OP_DT 2'h1
`define OCS_OP_INVERSE_TIME_MODE 2'h2
// Node mode codes.
`define OCS_NODE_ON 3'h1
`define OCS_NODE_BLOCKED 3'h2
`define OCS_NODE_TEST 3'h3
`define OCS_NODE_TESTBLK 3'h4
`define OCS_NODE_OFF 3'h5
// Forced status codes.
`define OCS_FORCE_NORMAL 5'h00
`define OCS_FORCE_START 5'h01
`define OCS_FORCE_TRIP 5'h02
`define OCS_FORCE_BLOCKED 5'h03
`define OCS_FORCE_START_A 5'h04
`define OCS_FORCE_TRIP_A 5'h07
`define OCS_FORCE_START_AB 5'h0A
`define OCS_FORCE_START_ABC 5'h0D
`define OCS_FORCE_TRIP_ABC 5'h11
`endif

// ===== ocs_stage.v
// Behaviour
// - Reset default: delayed release, 60 ms, hold.
// - Continued counting trips only after renewed pick-up.
// - No delayed release: clear counter on drop.
// - Delayed release, options off: freeze counter.
// - Timer reset option: counter counts down.
// - Forcing sets status; measurements still act.
// - Forced status codes, default normal.
// - Magnitude select RMS, TRMS, peak-to-peak.
// - Phase magnitudes consumed every 5 ms.
// - Pre-fault value is 20 ms average.
// - Side select between two modules.
// - Pick-up when any phase exceeds threshold.
// - Release below 97 percent of threshold.
// - Threshold in 0.01 nominal units, 1.20.
// - Start rises only while blocking inactive.
// - Outputs with ON/OFF events, 1 ms stamps.
// - Instant mode: start and trip together.
// - Cumulative event counters, clearable.
// - Eight setting groups, changeable at run.
// - Comm-bus threshold write gated, default off.
// - Node mode codes one to five.
// - Instant or definite-time operation; the inverse-time code runs as definite time.
// - Blocking at pick-up asserts blocked, drops start.
// - Release delay in 5 ms steps, 60 ms.
`timescale 1ns/100ps
`include "ocs_defs.vh"
module ocs_stage #(
   parameter MW = 16,
   parameter TICK_CYCLES = `OCS_TICK_CYCLES,
   parameter SAMPLE_MS = `OCS_SAMPLE_MS
) (
   input wire REF_CLK, // System clock, 40 MHz.
   input wire RESETN, // Asynchronous reset, active low.
   input wire [MW*9-1:0] SIDE1_MAG, // Side 1 magnitudes: RMS, TRMS, PP for A,B,C.
   input wire [MW*9-1:0] SIDE2_MAG, // Side 2 magnitudes, same layout.
   input wire SIDE_SEL, // Measurement side: 0 side 1, 1 side 2.
   input wire [1:0] MAG_SEL, // Magnitude selector code.
   input wire BLOCK_IN, // Blocking input from other clock domain.
   input wire [2:0] GROUP_SEL, // Active setting group.
   input wire [16*8-1:0] GROUP_THR, // Per-group threshold, 0.01 x nominal units.
   input wire [16*8-1:0] GROUP_DELAY, // Per-group operate delay, 5 ms steps.
   input wire [2*8-1:0] GROUP_OPMODE, // Per-group operating mode.
   input wire [8-1:0] GROUP_DLY_REL, // Per-group delayed release enable.
   input wire [8*8-1:0] GROUP_REL_STEPS, // Per-group release delay, 5 ms steps.
   input wire [8-1:0] GROUP_TMR_RST, // Per-group timer reset after release.
   input wire [8-1:0] GROUP_CONT, // Per-group continue counting.
   input wire GROUPS_VALID, // Group settings loaded; else defaults apply, except delay and mode.
   input wire COMM_CTRL_EN, // Comm bus may alter threshold.
   input wire COMM_THR_WE, // Comm bus threshold write strobe.
   input wire [15:0] COMM_THR, // Comm bus threshold value.
   input wire [2:0] NODE_MODE, // Node mode code.
   input wire FORCE_EN, // Global stage forcing enable.
   input wire [4:0] FORCE_STATUS, // Forced status code.
   input wire CNT_CLEAR, // Clear cumulative counters.
   output reg START, // Start output.
   output reg TRIP, // Trip output.
   output reg BLOCKED, // Blocked output.
   output reg [2:0] PHASE_START, // Per-phase start.
   output reg EVT_VALID, // Event pulse.
   output reg [2:0] EVT_SRC, // Event source, one-hot: 1 start, 2 trip, 4 blocked.
   output reg EVT_ON, // Event polarity: 1 ON, 0 OFF.
   output reg [31:0] EVT_STAMP, // Event time stamp in ms.
   output reg [MW-1:0] EVT_PREFAULT, // Pre-fault 20 ms average.
   output reg EVT2_VALID, // Paired trip event when start and trip change together.
   output reg [15:0] START_CNT, // Cumulative start count.
   output reg [15:0] TRIP_CNT, // Cumulative trip count.
   output reg [15:0] BLOCK_CNT // Cumulative blocked count.
);
   localparam ST_IDLE = 2'h0;
   localparam ST_RUN = 2'h1;
   localparam ST_REL = 2'h2;
   localparam ST_BLK = 2'h3;
   localparam [31:0] REL_RST_W = `OCS_REL_STEPS_RST;
   localparam [31:0] HYS_NUM_W = `OCS_HYS_NUM, HYS_DEN_W = `OCS_HYS_DEN;
   reg [31:0] tick_cnt_reg;
   reg [31:0] ms_reg;
   reg [2:0] samp_cnt_reg;
   reg samp_en;
   reg [2:0] blk_sync_reg;
   reg blk_reg;
   reg [15:0] thr_comm_reg;
   reg thr_comm_valid_reg;
   reg [1:0] state_reg;
   reg [15:0] op_cnt_reg;
   reg [7:0] rel_cnt_reg;
   reg [2:0] pick_reg;
   reg [MW-1:0] hist_reg [0:3];
   reg [1:0] hist_ptr_reg;
   reg start_int, trip_int, blk_int;
   reg [2:0] ph_int;
   reg prev_start_reg, prev_trip_reg, prev_blk_reg;
   wire [MW*9-1:0] side_mag = SIDE_SEL ? SIDE2_MAG : SIDE1_MAG;
   wire [1:0] mag_idx = (MAG_SEL == `OCS_MAG_TRMS) ? 2'd1 :
                        (MAG_SEL == `OCS_MAG_PP) ? 2'd2 : 2'd0;
   // Setting group selection; settings may change at any time.
   wire [15:0] g_thr = GROUPS_VALID ? GROUP_THR[GROUP_SEL*16 +: 16] : `OCS_THR_RST;
   wire [15:0] g_delay = GROUP_DELAY[GROUP_SEL*16 +: 16];
   wire [1:0] g_mode = GROUP_OPMODE[GROUP_SEL*2 +: 2];
   wire g_dly_rel = GROUPS_VALID ? GROUP_DLY_REL[GROUP_SEL] : 1'b1;
   wire [7:0] g_rel = GROUPS_VALID ? GROUP_REL_STEPS[GROUP_SEL*8 +: 8] :
                      REL_RST_W[7:0];
   wire g_tmr_rst = GROUPS_VALID ? GROUP_TMR_RST[GROUP_SEL] : 1'b0;
   wire g_cont = GROUPS_VALID ? GROUP_CONT[GROUP_SEL] : 1'b0;
   wire [15:0] thr = thr_comm_valid_reg ? thr_comm_reg : g_thr;
   wire node_off = (NODE_MODE == `OCS_NODE_OFF);
   wire node_blk = (NODE_MODE == `OCS_NODE_BLOCKED) || (NODE_MODE == `OCS_NODE_TESTBLK);
   wire pickup = |pick_reg;
   // Averaged history over the last four 5 ms samples.
   wire [MW+1:0] hist_sum = {2'b00, hist_reg[0]} + {2'b00, hist_reg[1]} +
                            {2'b00, hist_reg[2]} + {2'b00, hist_reg[3]};
   reg [MW-1:0] max_mag;
   reg [MW-1:0] phm;
   integer i, j;
   always @* begin
      max_mag = {MW{1'b0}};
      phm = {MW{1'b0}};
      for (j = 0; j < 3; j = j + 1) begin
         phm = side_mag[(j*3 + mag_idx)*MW +: MW];
         if (phm > max_mag) max_mag = phm;
      end
   end
   // Millisecond stamp and 5 ms sample enable.
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         tick_cnt_reg <= 32'h0;
         ms_reg <= 32'h0;
         samp_cnt_reg <= 3'h0;
         samp_en <= 1'b0;
      end else begin
         samp_en <= 1'b0;
         if (tick_cnt_reg == TICK_CYCLES - 1) begin
            tick_cnt_reg <= 32'h0;
            ms_reg <= ms_reg + 32'h1;
            if (samp_cnt_reg == SAMPLE_MS - 1) begin
               samp_cnt_reg <= 3'h0;
               samp_en <= 1'b1;
            end else begin
               samp_cnt_reg <= samp_cnt_reg + 3'h1;
            end
         end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
         end
      end
   end
   // Blocking input synchroniser; a change counts once stages two and three agree.
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         blk_sync_reg <= 3'h0;
         blk_reg <= 1'b0;
      end else begin
         blk_sync_reg <= {blk_sync_reg[1:0], BLOCK_IN};
         if (blk_sync_reg[2] == blk_sync_reg[1]) blk_reg <= blk_sync_reg[2];
      end
   end
   // Comm bus threshold override, accepted only when enabled.
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         thr_comm_reg <= `OCS_THR_RST;
         thr_comm_valid_reg <= 1'b0;
      end else if (!COMM_CTRL_EN) begin
         thr_comm_valid_reg <= 1'b0;
      end else if (COMM_THR_WE) begin
         thr_comm_reg <= COMM_THR;
         thr_comm_valid_reg <= 1'b1;
      end
   end
   // Per-phase comparators with fixed 97 percent reset ratio; magnitude is in threshold units.
   genvar p;
   generate
      for (p = 0; p < 3; p = p + 1) begin : g_ph
         wire [MW-1:0] m = side_mag[(p*3 + mag_idx)*MW +: MW];
         wire [MW+7:0] m_s = {8'h0, m} * HYS_DEN_W[7:0];
         wire [MW+7:0] t_s = {8'h0, thr} * HYS_NUM_W[7:0];
         always @(posedge REF_CLK or negedge RESETN) begin
            if (!RESETN) pick_reg[p] <= 1'b0;
            else if (samp_en) begin
               if (m > thr) pick_reg[p] <= 1'b1;
               else if (m_s < t_s) pick_reg[p] <= 1'b0;
            end
         end
      end
   endgenerate
   // Pre-fault history of the selected highest phase magnitude.
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         hist_ptr_reg <= 2'h0;
         for (i = 0; i < 4; i = i + 1) hist_reg[i] <= {MW{1'b0}};
      end else if (samp_en) begin
         hist_reg[hist_ptr_reg] <= max_mag;
         hist_ptr_reg <= hist_ptr_reg + 2'h1;
      end
   end
   // Stage timing state machine, advanced each 5 ms program cycle.
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_reg <= ST_IDLE;
         op_cnt_reg <= 16'h0;
         rel_cnt_reg <= 8'h0;
      end else if (node_off) begin
         state_reg <= ST_IDLE;
         op_cnt_reg <= 16'h0;
      end else if (samp_en) begin
         case (state_reg)
            ST_IDLE: begin
               op_cnt_reg <= 16'h0;
               if (pickup && (blk_reg || node_blk)) state_reg <= ST_BLK;
               else if (pickup) state_reg <= ST_RUN;
            end
            ST_RUN: begin
               if (blk_reg || node_blk) begin
                  state_reg <= ST_BLK;
                  op_cnt_reg <= 16'h0;
               end else if (!pickup) begin
                  if (g_dly_rel && g_mode != `OCS_OP_INSTANT) begin
                     state_reg <= ST_REL;
                     rel_cnt_reg <= g_rel;
                  end else begin
                     state_reg <= ST_IDLE;
                     op_cnt_reg <= 16'h0;
                  end
               end else if (op_cnt_reg < g_delay) begin
                  op_cnt_reg <= op_cnt_reg + 16'h1;
               end
            end
            ST_REL: begin
               if (pickup) state_reg <= ST_RUN;
               else if (rel_cnt_reg <= 8'h1) begin
                  state_reg <= ST_IDLE;
                  op_cnt_reg <= 16'h0;
               end else begin
                  rel_cnt_reg <= rel_cnt_reg - 8'h1;
                  if (g_cont && op_cnt_reg < g_delay - 16'h1)
                     op_cnt_reg <= op_cnt_reg + 16'h1;
                  else if (g_tmr_rst && op_cnt_reg != 16'h0)
                     op_cnt_reg <= op_cnt_reg - 16'h1;
                  // Otherwise the count is frozen.
               end
            end
            ST_BLK: begin
               op_cnt_reg <= 16'h0;
               if (!pickup || !(blk_reg || node_blk)) state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
   // Output decode with forcing override; forcing overlays measured status.
   always @* begin
      start_int = (state_reg == ST_RUN) || (state_reg == ST_REL);
      trip_int = (state_reg == ST_RUN) && pickup &&
                 ((g_mode == `OCS_OP_INSTANT) || (op_cnt_reg >= g_delay));
      blk_int = (state_reg == ST_BLK);
      ph_int = start_int ? pick_reg : 3'h0;
      if (FORCE_EN) begin
         case (FORCE_STATUS)
            `OCS_FORCE_START: begin start_int = 1'b1; ph_int = 3'h7; end
            `OCS_FORCE_TRIP: begin start_int = 1'b1; trip_int = 1'b1; ph_int = 3'h7; end
            `OCS_FORCE_BLOCKED: blk_int = 1'b1;
            `OCS_FORCE_START_ABC: begin start_int = 1'b1; ph_int = 3'h7; end
            `OCS_FORCE_TRIP_ABC: begin start_int = 1'b1; trip_int = 1'b1; ph_int = 3'h7; end
            default: begin
               if (FORCE_STATUS >= `OCS_FORCE_START_A && FORCE_STATUS < `OCS_FORCE_TRIP_A) begin
                  start_int = 1'b1;
                  ph_int = 3'h1 << (FORCE_STATUS - `OCS_FORCE_START_A);
               end else if (FORCE_STATUS >= `OCS_FORCE_TRIP_A &&
                            FORCE_STATUS < `OCS_FORCE_START_AB) begin
                  start_int = 1'b1;
                  trip_int = 1'b1;
                  ph_int = 3'h1 << (FORCE_STATUS - `OCS_FORCE_TRIP_A);
               end else if (FORCE_STATUS > `OCS_FORCE_START_AB - 5'h1 &&
                            FORCE_STATUS < `OCS_FORCE_TRIP_ABC) begin
                  start_int = 1'b1;
                  trip_int = (FORCE_STATUS > `OCS_FORCE_START_ABC);
                  ph_int = (FORCE_STATUS == 5'h0A || FORCE_STATUS == 5'h0E) ? 3'h3 :
                           (FORCE_STATUS == 5'h0B || FORCE_STATUS == 5'h0F) ? 3'h6 : 3'h5;
               end
            end
         endcase
      end
   end
   // Outputs, time-stamped events and cumulative counters.
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         START <= 1'b0;
         TRIP <= 1'b0;
         BLOCKED <= 1'b0;
         PHASE_START <= 3'h0;
         prev_start_reg <= 1'b0;
         prev_trip_reg <= 1'b0;
         prev_blk_reg <= 1'b0;
         EVT_VALID <= 1'b0;
         EVT2_VALID <= 1'b0;
         EVT_SRC <= 3'h0;
         EVT_ON <= 1'b0;
         EVT_STAMP <= 32'h0;
         EVT_PREFAULT <= {MW{1'b0}};
         START_CNT <= 16'h0;
         TRIP_CNT <= 16'h0;
         BLOCK_CNT <= 16'h0;
      end else begin
         START <= start_int;
         TRIP <= trip_int;
         BLOCKED <= blk_int;
         PHASE_START <= ph_int;
         prev_start_reg <= start_int;
         prev_trip_reg <= trip_int;
         prev_blk_reg <= blk_int;
         EVT_VALID <= 1'b0;
         EVT2_VALID <= 1'b0;
         EVT_STAMP <= ms_reg;
         EVT_PREFAULT <= hist_sum[MW+1:2];
         if (start_int != prev_start_reg) begin
            EVT_VALID <= 1'b1;
            EVT_SRC <= 3'h1;
            EVT_ON <= start_int;
            EVT2_VALID <= (trip_int != prev_trip_reg);
         end else if (trip_int != prev_trip_reg) begin
            EVT_VALID <= 1'b1;
            EVT_SRC <= 3'h2;
            EVT_ON <= trip_int;
         end else if (blk_int != prev_blk_reg) begin
            EVT_VALID <= 1'b1;
            EVT_SRC <= 3'h4;
            EVT_ON <= blk_int;
         end
         // A simultaneous clear and count leaves the counter at one.
         START_CNT <= CNT_CLEAR ? 16'h0 : START_CNT;
         TRIP_CNT <= CNT_CLEAR ? 16'h0 : TRIP_CNT;
         BLOCK_CNT <= CNT_CLEAR ? 16'h0 : BLOCK_CNT;
         if (start_int && !prev_start_reg) START_CNT <= (CNT_CLEAR ? 16'h0 : START_CNT) + 16'h1;
         if (trip_int && !prev_trip_reg) TRIP_CNT <= (CNT_CLEAR ? 16'h0 : TRIP_CNT) + 16'h1;
         if (blk_int && !prev_blk_reg) BLOCK_CNT <= (CNT_CLEAR ? 16'h0 : BLOCK_CNT) + 16'h1;
      end
   end
endmodule // ocs_stage

// ===== ocs_meas_model.sv
`timescale 1ns/100ps
// Measurement module and blocking source seen by the stage. The chosen magnitude type on the
// chosen side carries the phase levels; every other slot reads zero.
module ocs_meas_model #(
   parameter MW = 16
) (
   input wire [3*MW-1:0] lvl, // Phase levels, A in the low slot.
   input wire [1:0] hot_type, // Type slot that carries the levels.
   input wire hot_side, // Side that carries the levels.
   input wire blk_req, // Blocking request.
   output reg [9*MW-1:0] side1_mag, // Side 1 magnitudes.
   output reg [9*MW-1:0] side2_mag, // Side 2 magnitudes.
   output wire block_out // Blocking line.
);
   integer p;
   // Places each phase level in its slot, so a wrong type or side selection reads zero.
   always @* begin
      side1_mag = {9*MW{1'b0}};
      side2_mag = {9*MW{1'b0}};
      for (p = 0; p < 3; p = p + 1) begin
         if (hot_side) begin
            side2_mag[(p*3+hot_type)*MW +: MW] = lvl[p*MW +: MW];
         end else begin
            side1_mag[(p*3+hot_type)*MW +: MW] = lvl[p*MW +: MW];
         end
      end
   end
   // The blocking line follows the request directly.
   assign block_out = blk_req;
endmodule // ocs_meas_model

// ===== ocs_stage_sva.sv
`timescale 1ns/100ps
`include "ocs_defs.vh"
// Port checker for one overcurrent stage.
module ocs_stage_sva #(
   parameter TICK_CYCLES = 4,
   parameter SAMPLE_MS = 5
) (
   input wire REF_CLK, // Stage clock.
   input wire RESETN, // Active-low reset.
   input wire FORCE_EN, // Forcing enable.
   input wire CNT_CLEAR, // Counter clear.
   input wire [2:0] NODE_MODE, // Node mode code.
   input wire START, // Start output.
   input wire TRIP, // Trip output.
   input wire BLOCKED, // Blocked output.
   input wire EVT_VALID, // Event pulse.
   input wire [2:0] EVT_SRC, // Event source.
   input wire EVT_ON, // Event polarity.
   input wire EVT2_VALID, // Paired trip event.
   input wire [15:0] START_CNT, // Start count.
   input wire [15:0] TRIP_CNT, // Trip count.
   input wire [15:0] BLOCK_CNT // Blocked count.
);
   localparam int SETTLE = 3 * TICK_CYCLES * SAMPLE_MS;
   reg [31:0] off_cnt_reg;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RESETN);
   // Counts clocks with the node off; the state returns to idle on the next clock, without a sample enable.
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         off_cnt_reg <= 32'h0;
      end else if (NODE_MODE != `OCS_NODE_OFF) begin
         off_cnt_reg <= 32'h0;
      end else if (off_cnt_reg < SETTLE) begin
         off_cnt_reg <= off_cnt_reg + 32'h1;
      end
   end
   // Output and event relations.
   start_unblocked_a: assert property ($rose(START) |-> !BLOCKED)
      else $error("start rose while blocked");
   trip_needs_start_a: assert property (TRIP && !FORCE_EN |-> START)
      else $error("trip without start");
   trip_drops_a: assert property ($fell(START) |-> !TRIP)
      else $error("trip held after start fell");
   start_event_a: assert property ($rose(START) && !FORCE_EN |-> EVT_VALID && EVT_ON && EVT_SRC == 3'h1)
      else $error("no start on event");
   start_count_a: assert property ($rose(START) && !FORCE_EN && !$past(CNT_CLEAR) |-> START_CNT == $past(START_CNT) + 16'h1)
      else $error("start count not stepped");
   instant_pair_a: assert property (EVT2_VALID |-> EVT_VALID && EVT_SRC == 3'h1 && START == EVT_ON && TRIP == EVT_ON)
      else $error("trip event not paired with start");
   pair_pulse_a: assert property (EVT2_VALID |=> !EVT2_VALID)
      else $error("paired event longer than a cycle");
   counts_clear_a: assert property (CNT_CLEAR ##1 !EVT_VALID |-> START_CNT == 16'h0 && TRIP_CNT == 16'h0 && BLOCK_CNT == 16'h0)
      else $error("counters not cleared");
   node_off_a: assert property (off_cnt_reg == SETTLE |-> !START && !TRIP)
      else $error("stage active with node off");
   // Main scenarios reached.
   cover property ($rose(TRIP));
   cover property ($rose(BLOCKED));
   cover property (EVT2_VALID);
   cover property ($fell(START) ##1 !START);
endmodule // ocs_stage_sva
bind ocs_stage ocs_stage_sva #(.TICK_CYCLES(TICK_CYCLES), .SAMPLE_MS(SAMPLE_MS)) i_ocs_stage_sva (.*);

// ===== ocs_stage_tb.sv
`timescale 1ns/100ps
`include "ocs_defs.vh"
// Self-checking bench for one overcurrent stage; a sample period is 20 clocks here.
module ocs_stage_tb;
   localparam MW = 16;
   localparam SP = 20;
   reg REF_CLK = 1'b0;
   reg RESETN = 1'b0;
   wire [MW*9-1:0] SIDE1_MAG;
   wire [MW*9-1:0] SIDE2_MAG;
   wire BLOCK_IN;
   reg SIDE_SEL = 1'b0;
   reg [1:0] MAG_SEL = `OCS_MAG_RMS;
   reg [2:0] GROUP_SEL = 3'h0;
   reg [127:0] GROUP_THR = 128'h0;
   reg [127:0] GROUP_DELAY = 128'h0;
   reg [15:0] GROUP_OPMODE = 16'h0;
   reg [7:0] GROUP_DLY_REL = 8'h0;
   reg [63:0] GROUP_REL_STEPS = 64'h0;
   reg [7:0] GROUP_TMR_RST = 8'h0;
   reg [7:0] GROUP_CONT = 8'h0;
   reg GROUPS_VALID = 1'b1;
   reg COMM_CTRL_EN = 1'b0;
   reg COMM_THR_WE = 1'b0;
   reg [15:0] COMM_THR = 16'h0;
   reg [2:0] NODE_MODE = `OCS_NODE_ON;
   reg FORCE_EN = 1'b0;
   reg [4:0] FORCE_STATUS = `OCS_FORCE_NORMAL;
   reg CNT_CLEAR = 1'b0;
   wire START, TRIP, BLOCKED, EVT_VALID, EVT_ON, EVT2_VALID;
   wire [2:0] PHASE_START, EVT_SRC;
   wire [31:0] EVT_STAMP;
   wire [MW-1:0] EVT_PREFAULT;
   wire [15:0] START_CNT, TRIP_CNT, BLOCK_CNT;
   reg [3*MW-1:0] lvl = 48'h0;
   reg [1:0] hot_type = 2'h0;
   reg hot_side = 1'b0;
   reg blk_req = 1'b0;
   integer fail_count = 0;
   integer compares = 0;
   integer cyc = 0;
   // Counts clocks since reset release; a millisecond is 4 of them here.
   always @(posedge REF_CLK) begin
      if (RESETN) cyc <= cyc + 1;
   end
   // Stage under test, with short ticks, and its measurement partner.
   ocs_stage #(.MW(MW), .TICK_CYCLES(4)) i_ocs_stage (.*);
   ocs_meas_model #(.MW(MW)) i_ocs_meas_model (.lvl(lvl), .hot_type(hot_type),
      .hot_side(hot_side), .blk_req(blk_req), .side1_mag(SIDE1_MAG),
      .side2_mag(SIDE2_MAG), .block_out(BLOCK_IN));
   // Clock of 25 ns.
   always #12.5 REF_CLK = ~REF_CLK;
   // Compares one value and reports a mismatch.
   task chk(input [31:0] seen, input [31:0] exp, input [8*10-1:0] what);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0s expected %0h seen %0h", what, exp, seen);
         end
      end
   endtask
   // Waits n sample periods and lands just after an edge.
   task samp(input integer n);
      begin
         repeat (n * SP) @(posedge REF_CLK);
         #1;
      end
   endtask
   // Lets one clock edge pass and lands just after it.
   task edge1;
      begin
         @(posedge REF_CLK);
         #1;
      end
   endtask
   // Loads one setting group.
   task grp(input [2:0] g, input [15:0] dly, input [1:0] md, input dr, input tr, input ct);
      begin
         GROUP_THR[g*16 +: 16] = 16'h0064;
         GROUP_DELAY[g*16 +: 16] = dly;
         GROUP_OPMODE[g*2 +: 2] = md;
         GROUP_DLY_REL[g] = dr;
         GROUP_REL_STEPS[g*8 +: 8] = 8'h08;
         GROUP_TMR_RST[g] = tr;
         GROUP_CONT[g] = ct;
      end
   endtask
   // Reset defaults: threshold 1.20 and a 60 ms release.
   task t_default;
      begin
         GROUPS_VALID = 1'b0;
         GROUP_SEL = 3'h2;
         lvl = 48'h78;
         samp(3);
         chk(START, 1'b0, "at_thr");
         lvl = 48'h79;
         samp(3);
         chk(START, 1'b1, "above_thr");
         lvl = 48'h0;
         samp(3);
         chk(START, 1'b1, "rel_hold");
         samp(12);
         chk(START, 1'b0, "rel_end");
         GROUPS_VALID = 1'b1;
         $display("t_default done");
      end
   endtask
   // Refused bus write, then the 97 percent reset ratio without delayed release.
   task t_hyst;
      begin
         lvl = 48'h3C;
         COMM_THR = 16'h0032;
         COMM_THR_WE = 1'b1;
         edge1;
         COMM_THR_WE = 1'b0;
         samp(3);
         chk(START, 1'b0, "comm_off");
         COMM_CTRL_EN = 1'b1;
         COMM_THR_WE = 1'b1;
         edge1;
         COMM_THR_WE = 1'b0;
         samp(3);
         chk(START, 1'b1, "comm_on");
         COMM_CTRL_EN = 1'b0;
         lvl = 48'h0;
         samp(3);
         lvl = 48'h65;
         samp(3);
         chk(START, 1'b1, "pick");
         lvl = 48'h62;
         samp(3);
         chk(START, 1'b1, "hyst_hold");
         lvl = 48'h60;
         samp(3);
         chk(START, 1'b0, "hyst_drop");
         $display("t_hyst done");
      end
   endtask
   // Delayed trip on phase C, counters and their clear.
   task t_trip;
      reg [15:0] n;
      begin
         GROUP_SEL = 3'h5;
         n = TRIP_CNT;
         lvl = {16'h0096, 32'h0};
         samp(2);
         chk(PHASE_START, 3'h4, "phase_c");
         chk(TRIP, 1'b0, "trip_early");
         samp(6);
         chk(TRIP, 1'b1, "trip");
         chk(TRIP_CNT, n + 16'h1, "trip_cnt");
         lvl = 48'h0;
         samp(11);
         chk({START, TRIP}, 2'h0, "released");
         CNT_CLEAR = 1'b1;
         edge1;
         CNT_CLEAR = 1'b0;
         edge1;
         chk({START_CNT, TRIP_CNT}, 32'h0, "cnt_clear");
         $display("t_trip done");
      end
   endtask
   // Instant mode: start and trip events together.
   task t_inst;
      integer i;
      begin
         GROUP_SEL = 3'h1;
         lvl = {16'h0, 16'h0096, 16'h0};
         i = 0;
         while (EVT2_VALID !== 1'b1 && i < 4 * SP) begin
            @(posedge REF_CLK);
            #1;
            i = i + 1;
         end
         chk({EVT2_VALID, EVT_VALID, EVT_SRC}, 5'h19, "pair_evt");
         chk(EVT_STAMP, (cyc - 1) / 4, "stamp");
         chk(EVT_PREFAULT, 16'h004B, "prefault");
         lvl = 48'h0;
         samp(3);
         chk({START, TRIP}, 2'h0, "inst_off");
         $display("t_inst done");
      end
   endtask
   // Blocking at pick-up, then node off.
   task t_block;
      reg [15:0] n;
      begin
         GROUP_SEL = 3'h2;
         n = BLOCK_CNT;
         blk_req = 1'b1;
         lvl = 48'h96;
         samp(3);
         chk({BLOCKED, START}, 2'h2, "blocked");
         chk(BLOCK_CNT, n + 16'h1, "blk_cnt");
         blk_req = 1'b0;
         lvl = 48'h0;
         samp(3);
         NODE_MODE = `OCS_NODE_OFF;
         lvl = 48'h96;
         samp(3);
         chk(START, 1'b0, "node_off");
         NODE_MODE = `OCS_NODE_ON;
         lvl = 48'h0;
         samp(3);
         $display("t_block done");
      end
   endtask
   // Each magnitude code, then side selection.
   task t_mag;
      reg [1:0] t;
      begin
         lvl = 48'h96;
         for (t = 2'h0; t < 2'h3; t = t + 2'h1) begin
            hot_type = t;
            MAG_SEL = t + 2'h1;
            samp(3);
            chk(START, 1'b1, "mag_sel");
            MAG_SEL = (t == 2'h2) ? 2'h1 : t + 2'h2;
            samp(3);
            chk(START, 1'b0, "mag_other");
         end
         hot_type = 2'h0;
         hot_side = 1'b1;
         MAG_SEL = `OCS_MAG_RMS;
         samp(3);
         chk(START, 1'b0, "side1");
         SIDE_SEL = 1'b1;
         samp(3);
         chk(START, 1'b1, "side2");
         lvl = 48'h0;
         SIDE_SEL = 1'b0;
         hot_side = 1'b0;
         samp(3);
         $display("t_mag done");
      end
   endtask
   // Gap in pick-up with hold, count-down and continued counting.
   task t_release;
      integer k;
      begin
         for (k = 0; k < 3; k = k + 1) begin
            GROUP_SEL = (k == 0) ? 3'h0 : k[2:0] + 3'h2;
            lvl = 48'h96;
            samp(6);
            lvl = 48'h0;
            samp(3);
            if (k != 2) begin
               lvl = 48'h96;
            end
            samp(8);
            chk(TRIP, k == 0, "rel_trip");
            lvl = 48'h0;
            samp(12);
         end
         $display("t_release done");
      end
   endtask
   // Forced start without current, then back to normal.
   task t_force;
      begin
         GROUP_SEL = 3'h2;
         FORCE_EN = 1'b1;
         FORCE_STATUS = `OCS_FORCE_START;
         samp(3);
         chk(START, 1'b1, "forced");
         FORCE_STATUS = 5'h10;
         samp(1);
         chk({TRIP, PHASE_START}, 4'hD, "trip_ca");
         FORCE_STATUS = `OCS_FORCE_NORMAL;
         samp(3);
         chk(START, 1'b0, "normal");
         FORCE_EN = 1'b0;
         $display("t_force done");
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task print_verdict;
      begin
         $display("compares %0d mismatches %0d", compares, fail_count);
         if (fail_count == 0 && compares > 0) begin
            $display("TB: PASS");
         end else begin
            $display("TB: FAIL");
         end
         $finish;
      end
   endtask
   // Cuts a hang short well after the expected run length.
   initial begin
      #300000;
      fail_count = fail_count + 1;
      print_verdict;
   end
   // Main sequence.
   initial begin
      grp(3'h0, 16'h000A, `OCS_OP_DT, 1'b1, 1'b0, 1'b0);
      grp(3'h1, 16'h0000, `OCS_OP_INSTANT, 1'b0, 1'b0, 1'b0);
      grp(3'h2, 16'h0064, `OCS_OP_DT, 1'b0, 1'b0, 1'b0);
      grp(3'h3, 16'h000A, `OCS_OP_DT, 1'b1, 1'b1, 1'b0);
      grp(3'h4, 16'h000A, `OCS_OP_DT, 1'b1, 1'b0, 1'b1);
      grp(3'h5, 16'h0004, `OCS_OP_INVERSE_TIME_MODE, 1'b1, 1'b0, 1'b0);
      repeat (2) @(posedge REF_CLK);
      #1;
      RESETN = 1'b1;
      t_default;
      t_hyst;
      t_trip;
      t_inst;
      t_block;
      t_mag;
      t_release;
      t_force;
      print_verdict;
   end
endmodule // ocs_stage_tb
